// file: hw/pmcg_top.v
// Power mode and clock gating controller with AXI4-Lite register access
//
// Behaviour
// - Setting stop-select enters Stop once the setting instruction has completed.
// - In Stop, CPU clock and precision oscillator are halted.
// - Stop leaves low-power and external oscillator states unchanged.
// - Only an internal or external reset ends Stop.
// - Reset ending Stop runs normal reset, fetch restarts at address zero.
// - Enabled missing-clock detector timeout in Stop raises internal reset.
// - With low-power enable set, entering Idle gates the CPU clock.
// - In Low Power Active, a force bit clocks its peripheral regardless of gate.
// - With low-power enable set and force bits at reset value, gate enables alone decide clocking.
// - In Low Power Active the CPU clock always runs.
`timescale 1ns/1ps
`include "pmcg_consts.vh"

module pmcg_top
#(
	parameter NUM_PERIPH  = 8,
	parameter TIMEOUT_CYC = `PMCG_MCD_TIMEOUT_CYC
)
(
	input  wire                  aclk,
	input  wire                  aresetn,
	input  wire [3:0]            s_axi_awaddr,
	input  wire                  s_axi_awvalid,
	output reg                   s_axi_awready,
	input  wire [31:0]           s_axi_wdata,
	input  wire [3:0]            s_axi_wstrb,
	input  wire                  s_axi_wvalid,
	output reg                   s_axi_wready,
	output reg  [1:0]            s_axi_bresp,
	output reg                   s_axi_bvalid,
	input  wire                  s_axi_bready,
	input  wire [3:0]            s_axi_araddr,
	input  wire                  s_axi_arvalid,
	output reg                   s_axi_arready,
	output reg  [31:0]           s_axi_rdata,
	output reg  [1:0]            s_axi_rresp,
	output reg                   s_axi_rvalid,
	input  wire                  s_axi_rready,
	input  wire                  instr_done,
	input  wire                  ext_reset_req,
	input  wire                  mcd_clock_seen,
	input  wire                  lpo_run_in,
	input  wire                  extosc_run_in,
	output reg                   cpu_clk_en,
	output reg                   precision_osc_en,
	output reg                   lpo_run,
	output reg                   extosc_run,
	output reg  [NUM_PERIPH-1:0] periph_clk_en,
	output reg                   internal_reset,
	output reg                   cpu_fetch_restart,
	output wire [NUM_PERIPH-1:0] gated_periph_clk
);

	// ------------------------------------------------------------------------
	// Power state machine
	// ------------------------------------------------------------------------
	localparam ST_RUN        = 2'b00;
	localparam ST_IDLE       = 2'b01;
	localparam ST_STOP_PEND  = 2'b10;
	localparam ST_STOP       = 2'b11;

	reg  [1:0]            state_reg;
	reg  [1:0]            state_next;
	reg                   low_power_mode_enable;
	reg                   mcd_enable;
	reg  [NUM_PERIPH-1:0] peripheral_clock_gate_enable;
	reg  [NUM_PERIPH-1:0] active_clock_force;
	reg                   idle_req_reg;
	reg                   stop_req_reg;
	reg                   reset_pend_reg;
	wire                  mcd_timeout;
	wire                  reset_event;

	// ------------------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------------------
	reg  [3:0]            awaddr_reg;
	reg                   aw_held_reg;
	reg  [31:0]           wdata_reg;
	reg  [3:0]            wstrb_reg;
	reg                   w_held_reg;
	wire                  do_write;
	reg                   wr_ok;
	reg  [31:0]           rd_data;
	reg                   rd_ok;

	assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg   <= 1'b0;
			w_held_reg    <= 1'b0;
			awaddr_reg    <= 4'h0;
			wdata_reg     <= 32'h0000_0000;
			wstrb_reg     <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PMCG_RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			if (s_axi_awvalid && !aw_held_reg && !s_axi_awready)
			begin
				s_axi_awready <= 1'b1;
				aw_held_reg   <= 1'b1;
				awaddr_reg    <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held_reg && !s_axi_wready)
			begin
				s_axi_wready <= 1'b1;
				w_held_reg   <= 1'b1;
				wdata_reg    <= s_axi_wdata;
				wstrb_reg    <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `PMCG_RESP_OKAY : `PMCG_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always @*
	begin
		case (awaddr_reg)
			`PMCG_OFF_POWER_CONTROL: wr_ok = 1'b1;
			`PMCG_OFF_CLOCK_MODE:    wr_ok = 1'b1;
			`PMCG_OFF_GATE_ENABLE:   wr_ok = 1'b1;
			`PMCG_OFF_ACTIVE_FORCE:  wr_ok = 1'b1;
			default:                 wr_ok = 1'b0;
		endcase
	end

	always @*
	begin
		rd_data = 32'h0000_0000;
		rd_ok   = 1'b1;
		case (s_axi_araddr)
			`PMCG_OFF_POWER_CONTROL:
			begin
				rd_data[`PMCG_PC_IDLE_BIT] = idle_req_reg;
				rd_data[`PMCG_PC_STOP_BIT] = stop_req_reg;
			end
			`PMCG_OFF_CLOCK_MODE:
			begin
				rd_data[`PMCG_CM_LPM_EN_BIT]  = low_power_mode_enable;
				rd_data[`PMCG_CM_MCD_EN_BIT]  = mcd_enable;
				rd_data[`PMCG_CM_IDLE_ST_BIT] = (state_reg == ST_IDLE);
				rd_data[`PMCG_CM_STOP_ST_BIT] = (state_reg == ST_STOP);
				rd_data[`PMCG_CM_LPA_ST_BIT]  = low_power_mode_enable && (state_reg == ST_RUN);
			end
			`PMCG_OFF_GATE_ENABLE:
				rd_data[NUM_PERIPH-1:0] = peripheral_clock_gate_enable;
			`PMCG_OFF_ACTIVE_FORCE:
				rd_data[NUM_PERIPH-1:0] = active_clock_force;
			default:
				rd_ok = 1'b0;
		endcase
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `PMCG_RESP_OKAY;
		end
		else if (s_axi_rvalid)
		begin
			s_axi_arready <= 1'b0;
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
		else if (s_axi_arvalid && !s_axi_arready)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_data;
			s_axi_rresp   <= rd_ok ? `PMCG_RESP_OKAY : `PMCG_RESP_SLVERR;
		end
		else
			s_axi_arready <= 1'b0;
	end

	// ------------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------------
	// Software writes are ignored while stopped; the CPU cannot run then anyway
	always @(posedge aclk)
	begin
		if (!aresetn || reset_event)
		begin
			low_power_mode_enable        <= 1'b0;
			mcd_enable                   <= `PMCG_RST_MCD_EN;
			peripheral_clock_gate_enable <= {NUM_PERIPH{1'b0}};
			active_clock_force           <= {NUM_PERIPH{1'b0}};
			idle_req_reg                 <= 1'b0;
			stop_req_reg                 <= 1'b0;
		end
		else
		begin
			if (do_write && wstrb_reg[0] && state_reg != ST_STOP)
			begin
				case (awaddr_reg)
					`PMCG_OFF_POWER_CONTROL:
					begin
						idle_req_reg <= wdata_reg[`PMCG_PC_IDLE_BIT];
						stop_req_reg <= wdata_reg[`PMCG_PC_STOP_BIT];
					end
					`PMCG_OFF_CLOCK_MODE:
					begin
						low_power_mode_enable <= wdata_reg[`PMCG_CM_LPM_EN_BIT];
						mcd_enable            <= wdata_reg[`PMCG_CM_MCD_EN_BIT];
					end
					`PMCG_OFF_GATE_ENABLE:
						peripheral_clock_gate_enable <= wdata_reg[NUM_PERIPH-1:0];
					`PMCG_OFF_ACTIVE_FORCE:
						active_clock_force <= wdata_reg[NUM_PERIPH-1:0];
					default:
						idle_req_reg <= idle_req_reg;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------------
	// Missing-clock detector and reset generation
	// ------------------------------------------------------------------------
	pmcg_missing_clock #(
		.TIMEOUT_CYC (TIMEOUT_CYC)
	) u_mcd (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.enable     (mcd_enable),
		.clock_seen (mcd_clock_seen),
		.timeout    (mcd_timeout)
	);

	// Detector reset is honoured in any state, Stop included
	assign reset_event = ext_reset_req || mcd_timeout;

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			internal_reset    <= 1'b0;
			cpu_fetch_restart <= 1'b0;
			reset_pend_reg    <= 1'b0;
		end
		else
		begin
			internal_reset    <= mcd_timeout;
			reset_pend_reg    <= reset_event;
			// Restart pulse once the reset request falls: fetch from zero
			cpu_fetch_restart <= reset_pend_reg && !reset_event;
		end
	end

	// ------------------------------------------------------------------------
	// State transitions
	// ------------------------------------------------------------------------
	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN:
				if (stop_req_reg)
					state_next = ST_STOP_PEND;
				else if (idle_req_reg)
					state_next = ST_IDLE;
			ST_IDLE:
				if (!idle_req_reg)
					state_next = ST_RUN;
			ST_STOP_PEND:
				if (instr_done)
					state_next = ST_STOP;
			ST_STOP:
				state_next = ST_STOP;
			default:
				state_next = ST_RUN;
		endcase
		if (reset_event)
			state_next = ST_RUN;
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
			state_reg <= ST_RUN;
		else
			state_reg <= state_next;
	end

	// ------------------------------------------------------------------------
	// Clock enables
	// ------------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_PERIPH; g = g + 1)
		begin : g_periph
			always @(posedge aclk)
			begin
				if (!aresetn)
					periph_clk_en[g] <= 1'b1;
				else if (!low_power_mode_enable)
					periph_clk_en[g] <= 1'b1;
				else
					periph_clk_en[g] <= peripheral_clock_gate_enable[g]
						| active_clock_force[g];
			end

			pmcg_clock_gate u_gate (
				.clk_in  (aclk),
				.enable  (periph_clk_en[g]),
				.clk_out (gated_periph_clk[g])
			);
		end
	endgenerate

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cpu_clk_en       <= 1'b1;
			precision_osc_en <= 1'b1;
			lpo_run          <= 1'b0;
			extosc_run       <= 1'b0;
		end
		else
		begin
			// Stop halts core and precision oscillator; Low Power Active keeps core
			cpu_clk_en <= !(state_next == ST_STOP) &&
				!(state_next == ST_IDLE && low_power_mode_enable);
			precision_osc_en <= (state_next != ST_STOP);
			lpo_run          <= lpo_run_in;
			extosc_run       <= extosc_run_in;
		end
	end
endmodule // pmcg_top

// file: pkg/pmcg_consts.vh
// Register offsets, field positions, reset values and timing counts for the power mode controller
`ifndef PMCG_CONSTS_VH
`define PMCG_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define PMCG_OFF_POWER_CONTROL   4'h0
`define PMCG_OFF_CLOCK_MODE      4'h4
`define PMCG_OFF_GATE_ENABLE     4'h8
`define PMCG_OFF_ACTIVE_FORCE    4'hc

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PMCG_PC_IDLE_BIT         0
`define PMCG_PC_STOP_BIT         1
`define PMCG_PC_INSTR_DONE_BIT   2
`define PMCG_CM_LPM_EN_BIT       0
`define PMCG_CM_MCD_EN_BIT       1
`define PMCG_CM_IDLE_ST_BIT      4
`define PMCG_CM_STOP_ST_BIT      5
`define PMCG_CM_LPA_ST_BIT       6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PMCG_RST_GATE_ENABLE     8'h00
`define PMCG_RST_ACTIVE_FORCE    8'h00
`define PMCG_RST_MCD_EN          1'b0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define PMCG_CLK_PERIOD_NS       8
`define PMCG_MCD_TIMEOUT_US      100
`define PMCG_MCD_TIMEOUT_CYC     (`PMCG_MCD_TIMEOUT_US * 1000 / `PMCG_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------------------
`define PMCG_RESP_OKAY           2'b00
`define PMCG_RESP_SLVERR         2'b10

`endif

// file: hw/pmcg_clock_gate.v
// Glitch-free clock gate: enable captured on the falling clock edge
`timescale 1ns/1ps

module pmcg_clock_gate
(
	clk_in,
	enable,
	clk_out
);
	input  wire clk_in;
	input  wire enable;
	output wire clk_out;

	reg         en_reg;

	// Enable changes only on the falling edge, so the gate switches while the
	// clock is low and no runt pulse reaches the peripheral
	always @(negedge clk_in)
		en_reg <= enable;

	assign clk_out = clk_in & en_reg;
endmodule // pmcg_clock_gate

// file: hw/pmcg_missing_clock.v
// Missing-clock detector timeout counter, raises a reset request on expiry
`timescale 1ns/1ps
`include "pmcg_consts.vh"

module pmcg_missing_clock
#(
	parameter TIMEOUT_CYC = `PMCG_MCD_TIMEOUT_CYC
)
(
	aclk,
	aresetn,
	enable,
	clock_seen,
	timeout
);
	input  wire aclk;
	input  wire aresetn;
	input  wire enable;
	input  wire clock_seen;
	output reg  timeout;

	reg  [31:0] count_reg;

	// The reference clock edge is a sampled strobe; absence for the timeout
	// window means the monitored source stopped
	always @(posedge aclk)
	begin
		if (!aresetn || !enable || clock_seen)
		begin
			count_reg <= 32'h0000_0000;
			timeout   <= 1'b0;
		end
		else if (count_reg >= TIMEOUT_CYC - 1)
			timeout <= 1'b1;
		else
			count_reg <= count_reg + 32'h0000_0001;
	end
endmodule // pmcg_missing_clock

// file: verification/pmcg_assertions.sv
// Port-level checks for the power mode and clock gating controller
`timescale 1ns/1ps

module pmcg_assertions
#(
	parameter NUM_PERIPH  = 8,
	parameter TIMEOUT_CYC = 12500
)
(
	input wire                  aclk,
	input wire                  aresetn,
	input wire                  instr_done,
	input wire                  ext_reset_req,
	input wire                  lpo_run_in,
	input wire                  extosc_run_in,
	input wire                  cpu_clk_en,
	input wire                  precision_osc_en,
	input wire                  lpo_run,
	input wire                  extosc_run,
	input wire [NUM_PERIPH-1:0] periph_clk_en,
	input wire                  internal_reset,
	input wire                  cpu_fetch_restart,
	input wire [NUM_PERIPH-1:0] gated_periph_clk
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_stop_entry: assert property ($fell(precision_osc_en) |-> $past(instr_done))
		else $error("stop entered before the instruction completed");
	a_stop_both: assert property (!precision_osc_en |-> !cpu_clk_en)
		else $error("cpu clock runs while stopped");
	a_osc_pass: assert property ($past(aresetn) |-> lpo_run == $past(lpo_run_in)
		&& extosc_run == $past(extosc_run_in))
		else $error("oscillator state disturbed");
	a_stop_hold: assert property (!precision_osc_en && !ext_reset_req
		&& !$past(ext_reset_req) |=> (!precision_osc_en or ##[0:2] internal_reset))
		else $error("stop left without a reset");
	a_fetch_restart: assert property ($fell(ext_reset_req) |->
		##[0:2] (cpu_fetch_restart && precision_osc_en))
		else $error("no fetch restart after reset");
	a_mcd_reset: assert property ($rose(internal_reset) |-> ##[0:2] precision_osc_en)
		else $error("detector reset did not end stop");
	// Sampled just before the rising edge, every gated clock must be low
	a_gate_low: assert property (gated_periph_clk == '0)
		else $error("gated clock high while source clock low");
	a_gate_match: assert property (@(negedge aclk) $stable(periph_clk_en) |->
		gated_periph_clk == periph_clk_en)
		else $error("gated clocks differ from enables");
endmodule // pmcg_assertions

bind pmcg_top pmcg_assertions #(.NUM_PERIPH(NUM_PERIPH), .TIMEOUT_CYC(TIMEOUT_CYC)) i_chk (.*);

// file: verification/pmcg_cpu_model.sv
// Core-side model: completes instructions while clocked, ticks the watched clock
`timescale 1ns/1ps

module pmcg_cpu_model
(
	input  wire       aclk,
	input  wire       aresetn,
	input  wire       cpu_clk_en,
	input  wire       instr_go,
	input  wire [3:0] instr_len,
	input  wire       watch_alive,
	output reg        instr_done,
	output reg        mcd_clock_seen
);
	reg [3:0] icnt_reg;
	reg [1:0] wcnt_reg;

	// An instruction only progresses while the core is clocked
	always @(posedge aclk)
	begin
		if (!aresetn || !instr_go || !cpu_clk_en)
		begin
			icnt_reg   <= 4'h0;
			instr_done <= 1'b0;
		end
		else
		begin
			instr_done <= (icnt_reg == instr_len);
			icnt_reg   <= (icnt_reg == instr_len) ? 4'h0 : icnt_reg + 4'h1;
		end
	end

	// Ticks every fourth cycle, well inside the shortened detector timeout
	always @(posedge aclk)
	begin
		wcnt_reg       <= aresetn ? wcnt_reg + 2'h1 : 2'h0;
		mcd_clock_seen <= aresetn && watch_alive && (wcnt_reg == 2'h3);
	end
endmodule // pmcg_cpu_model

// file: verification/testbench.sv
// Self-checking bench for the power mode and clock gating controller
`timescale 1ns/1ps
`include "pmcg_consts.vh"

module testbench;
	localparam [3:0] PC = `PMCG_OFF_POWER_CONTROL;
	localparam [3:0] CM = `PMCG_OFF_CLOCK_MODE;
	localparam [3:0] GE = `PMCG_OFF_GATE_ENABLE;
	localparam [3:0] AF = `PMCG_OFF_ACTIVE_FORCE;
	localparam [1:0] OK = `PMCG_RESP_OKAY;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, instr_go, watch_alive;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, instr_len;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        instr_done, ext_reset_req, mcd_clock_seen, lpo_run_in, extosc_run_in;
	logic        cpu_clk_en, precision_osc_en, lpo_run, extosc_run;
	logic        internal_reset, cpu_fetch_restart;
	logic [7:0]  periph_clk_en, gated_periph_clk;
	logic [15:0] cases [4];
	integer      bad_count, n_tests, cyc, k, i;

	pmcg_top #(.NUM_PERIPH(8), .TIMEOUT_CYC(16)) i_pmcg_top (.*);
	pmcg_cpu_model i_pmcg_cpu_model (.*);

	initial aclk = 1'b0;
	always #4 aclk = ~aclk;

	task chk(input string n, input [31:0] s, input [31:0] e);
	begin
		n_tests = n_tests + 1;
		if (s !== e)
		begin
			bad_count = bad_count + 1;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	end
	endtask

	task results;
	begin
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask

	task tick(input integer n);
		repeat (n) @(posedge aclk);
	endtask

	task wr(input [3:0] a, input [31:0] d);
	begin
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", s_axi_bresp, OK);
	end
	endtask

	task rd(input [3:0] a, input [31:0] e, input [1:0] r);
	begin
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk("rdata", s_axi_rdata, e);
		chk("rresp", s_axi_rresp, r);
	end
	endtask

	// Runaway guard, far above the few hundred cycles the sequence needs
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			bad_count = bad_count + 1;
			results();
		end
	end

	initial
	begin
		bad_count = 0;
		n_tests = 0;
		cyc = 0;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 5'h0;
		{s_axi_rready, ext_reset_req, extosc_run_in} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
		s_axi_wstrb = 4'hf;
		{lpo_run_in, instr_go, watch_alive} = 3'h7;
		instr_len = 4'h0;
		cases = '{16'h5a00, 16'h0ff0, 16'h0081, 16'h0000};
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(GE, 32'h0, OK);
		rd(AF, 32'h0, OK);
		rd(CM, 32'h0, OK);
		rd(4'h2, 32'h0, `PMCG_RESP_SLVERR);
		wr(GE, 32'h05);
		tick(2);
		chk("periph_clk_en", periph_clk_en, 8'hff);
		for (i = 0; i < 4; i = i + 1)
		begin
			wr(CM, 32'h0);
			wr(GE, cases[i][15:8]);
			wr(AF, cases[i][7:0]);
			wr(CM, 32'h1);
			tick(2);
			chk("periph_clk_en", periph_clk_en, cases[i][15:8] | cases[i][7:0]);
			chk("cpu_clk_en", cpu_clk_en, 1'b1);
			// Look inside the high phase, away from either clock edge
			@(posedge aclk);
			#2;
			chk("gated", gated_periph_clk, cases[i][15:8] | cases[i][7:0]);
		end
		rd(CM, 32'h41, OK);
		wr(CM, 32'h0);
		wr(GE, 32'h03);
		wr(CM, 32'h1);
		wr(PC, 32'h1);
		tick(2);
		chk("cpu_clk_en", cpu_clk_en, 1'b0);
		wr(PC, 32'h0);
		tick(2);
		chk("cpu_clk_en", cpu_clk_en, 1'b1);
		wr(CM, 32'h0);
		instr_go <= 1'b0;
		wr(PC, 32'h2);
		tick(4);
		chk("precision_osc_en", precision_osc_en, 1'b1);
		instr_go <= 1'b1;
		instr_len <= 4'h5;
		k = 0;
		while (precision_osc_en !== 1'b0 && k < 20)
		begin
			@(posedge aclk);
			k = k + 1;
		end
		chk("precision_osc_en", precision_osc_en, 1'b0);
		chk("cpu_clk_en", cpu_clk_en, 1'b0);
		lpo_run_in <= 1'b0;
		extosc_run_in <= 1'b1;
		tick(2);
		chk("lpo_run", lpo_run, 1'b0);
		chk("extosc_run", extosc_run, 1'b1);
		wr(PC, 32'h0);
		tick(4);
		chk("precision_osc_en", precision_osc_en, 1'b0);
		ext_reset_req <= 1'b1;
		tick(2);
		ext_reset_req <= 1'b0;
		k = 0;
		while (cpu_fetch_restart !== 1'b1 && k < 10)
		begin
			@(posedge aclk);
			k = k + 1;
		end
		chk("cpu_fetch_restart", cpu_fetch_restart, 1'b1);
		chk("precision_osc_en", precision_osc_en, 1'b1);
		rd(GE, 32'h0, OK);
		wr(CM, 32'h2);
		tick(40);
		chk("internal_reset", internal_reset, 1'b0);
		wr(PC, 32'h2);
		tick(12);
		watch_alive <= 1'b0;
		k = 0;
		while (internal_reset !== 1'b1 && k < 40)
		begin
			@(posedge aclk);
			k = k + 1;
		end
		chk("internal_reset", internal_reset, 1'b1);
		watch_alive <= 1'b1;
		tick(4);
		chk("precision_osc_en", precision_osc_en, 1'b1);
		rd(CM, 32'h0, OK);
		results();
	end
endmodule // testbench
